// ---- lttp_top.sv ----
module lttp_top
#(
   parameter logic [lttp_pkg::QUAL_W-1:0] QUAL_T1_CYC =
      lttp_pkg::LOOP_QUAL_T1_CYC,
   parameter logic [lttp_pkg::QUAL_W-1:0] QUAL_E1_CYC =
      lttp_pkg::LOOP_QUAL_E1_CYC
)
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       clkTxLine,
   input  wire logic       regWrEn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   output      logic [7:0] regRdData,
   input  wire logic       hostModePin,
   input  wire logic       sendAllOnesPin,
   input  wire logic       autoAllOnesPin,
   input  wire logic       autoAllOnesBit,
   input  wire logic [2:0] testPatternSelect,
   input  wire logic [1:0] loopCodeDetectMode,
   input  wire logic       loopCodeIrqEnable,
   input  wire logic       rateIsE1,
   input  wire logic       txOnBit,
   input  wire logic       rxTermSelBit,
   input  wire logic       transmitOnPin,
   input  wire logic       rxTerminationSelect,
   input  wire logic       receiveSignalLoss,
   input  wire logic       txPositiveData,
   input  wire logic       txNegativeData,
   input  wire logic       rxLineData,
   output      logic       txLineTip,
   output      logic       txLineRing,
   output      logic       txEnable,
   output      logic       rxTermInternal,
   output      logic       loopCodeDetected,
   output      logic       remoteLoopback,
   output      logic       loopCodeIrq,
   output      logic       txLineClockLost
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]        handover;
      logic [7:0]        rdData;
      logic [1:0]        hostS;
      logic [1:0]        taosS;
      logic [1:0]        ataosS;
      logic [1:0]        onPinS;
      logic [1:0]        rxtPinS;
      logic [1:0]        rlosS;
      logic [1:0]        beatS;
      logic [1:0]        detS;
      logic [1:0]        remS;
      logic              beatPrev;
      logic              detPrev;
      logic [7:0]        lossCnt;
      logic              clkLost;
      logic [7:0]        divCnt;
      logic              fbPol;
      lttp_pkg::lttp_ami_t fb;
      logic [2:0]        patCode;
      logic              txEn;
      logic              rxTerm;
      logic              irq;
   } lttp_sys_reg_t;

   typedef struct packed {
      logic [1:0]        rstS;
      logic [2:0]        codeA;
      logic [2:0]        codeB;
      logic [1:0]        modeA;
      logic [1:0]        modeB;
      logic              e1A;
      logic              e1B;
      logic              beat;
      logic [2:0]        phase;
      logic              amiPol;
      lttp_pkg::lttp_ami_t ami;
   } lttp_link_reg_t;

   lttp_sys_reg_t  s_r;
   lttp_sys_reg_t  s_nxt;
   lttp_link_reg_t l_r;
   lttp_link_reg_t l_nxt;
   logic           host;
   logic           autoOn;
   logic           sendOnes;
   logic           markBit;
   logic           linkDet;
   logic           linkRem;
   logic           rstLink;

   assign host    = s_r.hostS[1];
   assign rstLink = l_r.rstS[1];

   // ---------------------------------------------------------------
   // Register access and pattern selection
   // ---------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.hostS   = {s_r.hostS[0], hostModePin};
      s_nxt.taosS   = {s_r.taosS[0], sendAllOnesPin};
      s_nxt.ataosS  = {s_r.ataosS[0], autoAllOnesPin};
      s_nxt.onPinS  = {s_r.onPinS[0], transmitOnPin};
      s_nxt.rxtPinS = {s_r.rxtPinS[0], rxTerminationSelect};
      s_nxt.rlosS   = {s_r.rlosS[0], receiveSignalLoss};
      s_nxt.beatS   = {s_r.beatS[0], l_r.beat};
      s_nxt.detS    = {s_r.detS[0], linkDet};
      s_nxt.remS    = {s_r.remS[0], linkRem};
      s_nxt.beatPrev = s_r.beatS[1];
      s_nxt.detPrev  = s_r.detS[1];
      if (regWrEn && (regAddr == lttp_pkg::PIN_CONTROL_HANDOVER_OFS))
         s_nxt.handover = regWrData;
      s_nxt.rdData = (regAddr == lttp_pkg::PIN_CONTROL_HANDOVER_OFS) ?
                     s_r.handover : 8'h00;
      if (host && !s_r.handover[lttp_pkg::TX_ENABLE_PIN_HANDOVER_BIT])
         s_nxt.txEn = txOnBit;
      else
         s_nxt.txEn = s_r.onPinS[1];
      if (host && !s_r.handover[lttp_pkg::RX_TERMINATION_PIN_HANDOVER_BIT])
         s_nxt.rxTerm = rxTermSelBit;
      else
         s_nxt.rxTerm = s_r.rxtPinS[1];
      autoOn   = s_r.ataosS[1] || (host && autoAllOnesBit);
      sendOnes = (testPatternSelect == lttp_pkg::PAT_ONES) ||
                 (!host && s_r.taosS[1]) ||
                 (autoOn && s_r.rlosS[1]);
      if (sendOnes)
         s_nxt.patCode = lttp_pkg::PAT_ONES;
      else if (!host && testPatternSelect[2])
         s_nxt.patCode = lttp_pkg::PAT_DATA;  // Pseudo-random is host only
      else
         s_nxt.patCode = testPatternSelect;
      // Line clock watchdog; a clock held low looks lost as well
      if (s_r.beatS[1] != s_r.beatPrev)
      begin
         s_nxt.lossCnt = 8'h00;
         s_nxt.clkLost = 1'b0;
      end
      else if (s_r.lossCnt == lttp_pkg::TX_CLK_LOSS_CYC)
         s_nxt.clkLost = 1'b1;
      else
         s_nxt.lossCnt = s_r.lossCnt + 8'h01;
      if (s_r.clkLost && (s_r.patCode == lttp_pkg::PAT_ONES))
      begin
         if (s_r.divCnt == lttp_pkg::FALLBACK_BIT_CYC)
         begin
            s_nxt.divCnt    = 8'h00;
            s_nxt.fbPol     = !s_r.fbPol;
            s_nxt.fb.txPos  = !s_r.fbPol;
            s_nxt.fb.txNeg  = s_r.fbPol;
         end
         else
            s_nxt.divCnt = s_r.divCnt + 8'h01;
      end
      else
      begin
         s_nxt.divCnt = 8'h00;
         s_nxt.fb     = '0;
      end
      s_nxt.irq = host && loopCodeIrqEnable &&
                  (s_r.detS[1] != s_r.detPrev);
      if (reset)
      begin
         s_nxt = '0;
         s_nxt.handover = lttp_pkg::PIN_CONTROL_HANDOVER_RST;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      s_r <= s_nxt;
   end

   // ---------------------------------------------------------------
   // Line clock side: code generation and AMI
   // ---------------------------------------------------------------
   // Code bits cross one by one; a skewed change costs at most one
   // line bit of the wrong pattern, acceptable for a test signal.
   always_comb
   begin
      l_nxt = l_r;
      l_nxt.rstS  = {l_r.rstS[0], reset};
      l_nxt.codeA = s_r.patCode;
      l_nxt.codeB = l_r.codeA;
      l_nxt.modeA = loopCodeDetectMode;
      l_nxt.modeB = l_r.modeA;
      l_nxt.e1A   = rateIsE1;
      l_nxt.e1B   = l_r.e1A;
      l_nxt.beat  = !l_r.beat;
      markBit     = 1'b0;
      case (l_r.codeB)
         lttp_pkg::PAT_ONES:
            markBit = 1'b1;
         lttp_pkg::PAT_LOOP_UP:
         begin
            markBit = (l_r.phase == lttp_pkg::UP_CODE_LAST);
            l_nxt.phase = (l_r.phase >= lttp_pkg::UP_CODE_LAST) ?
                          3'h0 : l_r.phase + 3'h1;
         end
         lttp_pkg::PAT_LOOP_DOWN:
         begin
            markBit = (l_r.phase == lttp_pkg::DOWN_CODE_LAST);
            l_nxt.phase = (l_r.phase >= lttp_pkg::DOWN_CODE_LAST) ?
                          3'h0 : l_r.phase + 3'h1;
         end
         default:
            l_nxt.phase = 3'h0;
      endcase
      if (l_r.codeB == lttp_pkg::PAT_ONES ||
          l_r.codeB == lttp_pkg::PAT_LOOP_UP ||
          l_r.codeB == lttp_pkg::PAT_LOOP_DOWN)
      begin
         l_nxt.ami.txPos = markBit && !l_r.amiPol;
         l_nxt.ami.txNeg = markBit && l_r.amiPol;
         l_nxt.amiPol    = l_r.amiPol ^ markBit;
      end
      else
      begin
         l_nxt.ami.txPos = txPositiveData;
         l_nxt.ami.txNeg = txNegativeData;
      end
      if (rstLink)
      begin
         l_nxt      = '0;
         l_nxt.rstS = {l_r.rstS[0], reset};
      end
   end

   always_ff @(posedge clkTxLine)
   begin
      l_r <= l_nxt;
   end

   lttp_loop_detect i_lttp_loop_detect
   (
      .clkTxLine          (clkTxLine),
      .rstLink            (rstLink),
      .rxLineData         (rxLineData),
      .loopCodeDetectMode (l_r.modeB),
      .suppressAuto       (l_r.codeB == lttp_pkg::PAT_LOOP_UP),
      .qualCycles         (l_r.e1B ? QUAL_E1_CYC : QUAL_T1_CYC),
      .loopCodeDetected   (linkDet),
      .remoteLoopback     (linkRem)
   );

   // Fallback owns the line only while the line clock is gone
   assign txLineTip        = s_r.clkLost ? s_r.fb.txPos : l_r.ami.txPos;
   assign txLineRing       = s_r.clkLost ? s_r.fb.txNeg : l_r.ami.txNeg;
   assign txEnable         = s_r.txEn;
   assign rxTermInternal   = s_r.rxTerm;
   assign loopCodeDetected = s_r.detS[1];
   assign remoteLoopback   = s_r.remS[1];
   assign loopCodeIrq      = s_r.irq;
   assign txLineClockLost  = s_r.clkLost;
   assign regRdData        = s_r.rdData;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_tx_handover;
      @(posedge clk_sys) disable iff (reset)
      (host && s_r.handover[5]) |=> (txEnable == $past(s_r.onPinS[1]));
   endproperty
   a_tx_handover: assert property (p_tx_handover)
      else $error("transmitter enable ignored its pin");

   property p_rx_handover;
      @(posedge clk_sys) disable iff (reset)
      (host && s_r.handover[4]) |=> (rxTermInternal == $past(s_r.rxtPinS[1]));
   endproperty
   a_rx_handover: assert property (p_rx_handover)
      else $error("receive termination ignored its pin");

   property p_hw_ones;
      @(posedge clk_sys) disable iff (reset)
      (!host && s_r.taosS[1]) |=> (s_r.patCode == 3'h1);
   endproperty
   a_hw_ones: assert property (p_hw_ones)
      else $error("all-ones pin not honoured");

   property p_loss_ones;
      @(posedge clk_sys) disable iff (reset)
      ((s_r.ataosS[1] || (host && autoAllOnesBit)) && s_r.rlosS[1]) |=>
         (s_r.patCode == 3'h1);
   endproperty
   a_loss_ones: assert property (p_loss_ones)
      else $error("no all ones on signal loss");

   property p_decode;
      @(posedge clk_sys) disable iff (reset)
      (host && testPatternSelect == 3'h3 && !s_r.rlosS[1]) |=>
         (s_r.patCode == 3'h3);
   endproperty
   a_decode: assert property (p_decode)
      else $error("pattern select misdecoded");

   property p_fallback;
      @(posedge clk_sys) disable iff (reset)
      (s_r.clkLost && s_r.patCode == 3'h1) |-> ##[1:170]
         (txLineTip || txLineRing || !s_r.clkLost || s_r.patCode != 3'h1);
   endproperty
   a_fallback: assert property (p_fallback)
      else $error("no fallback ones without line clock");

   property p_irq;
      @(posedge clk_sys) disable iff (reset)
      (host && loopCodeIrqEnable && $changed(loopCodeDetected)) |->
         ##1 loopCodeIrq ##1 !loopCodeIrq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("detection change raised no interrupt");

   property p_ami_ones;
      @(posedge clkTxLine) disable iff (rstLink)
      (l_r.codeB == 3'h1) |=> (l_r.ami.txPos != l_r.ami.txNeg) &&
         (l_r.ami.txPos == !$past(l_r.amiPol));
   endproperty
   a_ami_ones: assert property (p_ami_ones)
      else $error("all ones not AMI encoded");

   property p_up_code;
      @(posedge clkTxLine) disable iff (rstLink)
      (l_r.codeB == 3'h2 && l_r.phase < 3'h4) |=>
         !(l_r.ami.txPos || l_r.ami.txNeg);
   endproperty
   a_up_code: assert property (p_up_code)
      else $error("loop-up code has a mark out of place");

   property p_down_code;
      @(posedge clkTxLine) disable iff (rstLink)
      (l_r.codeB == 3'h3 && l_r.phase == 3'h2) |=>
         (l_r.ami.txPos || l_r.ami.txNeg);
   endproperty
   a_down_code: assert property (p_down_code)
      else $error("loop-down code lost its mark");

   c_fallback: cover property (@(posedge clk_sys) $rose(s_r.clkLost));
   c_irq: cover property (@(posedge clk_sys) loopCodeIrq);
   c_up: cover property (@(posedge clkTxLine) l_r.codeB == 3'h2);

endmodule

// ---- lttp_pkg.sv ----
package lttp_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] PIN_CONTROL_HANDOVER_OFS = 8'h12;
   localparam logic [7:0] PIN_CONTROL_HANDOVER_RST = 8'h00;
   localparam int         TX_ENABLE_PIN_HANDOVER_BIT      = 5;
   localparam int         RX_TERMINATION_PIN_HANDOVER_BIT = 4;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int SYS_CLK_HZ     = 250_000_000;
   localparam int SYS_CLK_NS     = 4;
   localparam int T1_RATE_HZ     = 1_544_000;
   localparam int E1_RATE_HZ     = 2_048_000;
   localparam int LOOP_QUAL_S    = 5;
   localparam int QUAL_W         = 24;
   localparam logic [QUAL_W-1:0] LOOP_QUAL_T1_CYC =
      QUAL_W'(LOOP_QUAL_S * T1_RATE_HZ);
   localparam logic [QUAL_W-1:0] LOOP_QUAL_E1_CYC =
      QUAL_W'(LOOP_QUAL_S * E1_RATE_HZ);
   // Longer than one slow line bit, so a running line clock never trips
   localparam int TX_CLK_LOSS_NS = 1000;
   localparam logic [7:0] TX_CLK_LOSS_CYC =
      8'(TX_CLK_LOSS_NS / SYS_CLK_NS);
   localparam logic [7:0] FALLBACK_BIT_CYC = 8'(SYS_CLK_HZ / T1_RATE_HZ);
   localparam logic [2:0] UP_CODE_LAST    = 3'h4;
   localparam logic [2:0] DOWN_CODE_LAST  = 3'h2;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PAT_DATA      = 3'h0,
      PAT_ONES      = 3'h1,
      PAT_LOOP_UP   = 3'h2,
      PAT_LOOP_DOWN = 3'h3,
      PAT_PRBS      = 3'h4,
      PAT_PRBS_INV  = 3'h5,
      PAT_PRBS_ERR  = 3'h6,
      PAT_PRBS_IERR = 3'h7
   } lttp_pattern_t;

   typedef enum logic [1:0] {
      LCD_OFF  = 2'h0,
      LCD_UP   = 2'h1,
      LCD_DOWN = 2'h2,
      LCD_AUTO = 2'h3
   } lttp_lcd_mode_t;

   typedef enum logic [1:0] {
      DET_IDLE    = 2'h0,
      DET_WAIT_UP = 2'h1,
      DET_LOOPED  = 2'h3
   } lttp_det_state_t;

   typedef struct packed {
      logic txPos;
      logic txNeg;
   } lttp_ami_t;

endpackage

// ---- lttp_loop_detect.sv ----
module lttp_loop_detect
(
   input  wire logic                           clkTxLine,
   input  wire logic                           rstLink,
   input  wire logic                           rxLineData,
   input  wire logic [1:0]                     loopCodeDetectMode,
   input  wire logic                           suppressAuto,
   input  wire logic [lttp_pkg::QUAL_W-1:0]    qualCycles,
   output      logic                           loopCodeDetected,
   output      logic                           remoteLoopback
);

   typedef struct packed {
      logic [4:0]                      hist;
      logic [lttp_pkg::QUAL_W-1:0]     cnt;
      logic [1:0]                      modePrev;
      lttp_pkg::lttp_det_state_t       state;
      logic                            det;
   } lttp_det_reg_t;

   lttp_det_reg_t s_r;
   lttp_det_reg_t s_nxt;
   logic          upOk;
   logic          downOk;
   logic          watchUp;
   logic          codeOk;
   logic          qualified;

   // ---------------------------------------------------------------
   // Code recognition and qualification
   // ---------------------------------------------------------------
   always_comb
   begin
      // One mark per period and periodic: any phase of 00001 or 001
      upOk    = ($countones({s_r.hist[3:0], rxLineData}) == 1) &&
                (rxLineData == s_r.hist[4]);
      downOk  = ($countones({s_r.hist[1:0], rxLineData}) == 1) &&
                (rxLineData == s_r.hist[2]);
      watchUp = (loopCodeDetectMode == lttp_pkg::LCD_UP) ||
                ((loopCodeDetectMode == lttp_pkg::LCD_AUTO) &&
                 (s_r.state != lttp_pkg::DET_LOOPED));
      codeOk  = watchUp ? upOk : downOk;
      qualified = codeOk && (s_r.cnt == qualCycles);
      s_nxt = s_r;
      s_nxt.hist = {s_r.hist[3:0], rxLineData};
      s_nxt.modePrev = loopCodeDetectMode;
      if (!codeOk || (loopCodeDetectMode != s_r.modePrev))
         s_nxt.cnt = '0;
      else if (s_r.cnt != qualCycles)
         s_nxt.cnt = s_r.cnt + 1'b1;
      if (loopCodeDetectMode != s_r.modePrev)
      begin
         s_nxt.state = lttp_pkg::DET_IDLE;
         s_nxt.det   = 1'b0;
      end
      else
      begin
         // Detection depends on the control mode: up and down follow the code, auto latches, off clears
         case (loopCodeDetectMode)
            lttp_pkg::LCD_UP, lttp_pkg::LCD_DOWN:
            begin
               s_nxt.state = lttp_pkg::DET_IDLE;
               s_nxt.det   = codeOk && (s_r.det || qualified);
            end
            lttp_pkg::LCD_AUTO:
            begin
               if (suppressAuto)
               begin
                  s_nxt.state = lttp_pkg::DET_IDLE;
                  s_nxt.det   = 1'b0;
               end
               else
               begin
                  case (s_r.state)
                     lttp_pkg::DET_LOOPED:
                     begin
                        if (qualified)
                        begin
                           s_nxt.state = lttp_pkg::DET_WAIT_UP;
                           s_nxt.det   = 1'b0;
                           s_nxt.cnt   = '0;
                        end
                     end
                     default:
                     begin
                        s_nxt.state = lttp_pkg::DET_WAIT_UP;
                        if (qualified)
                        begin
                           s_nxt.state = lttp_pkg::DET_LOOPED;
                           s_nxt.det   = 1'b1;
                           s_nxt.cnt   = '0;
                        end
                     end
                  endcase
               end
            end
            default:
            begin
               s_nxt.state = lttp_pkg::DET_IDLE;
               s_nxt.det   = 1'b0;
            end
         endcase
      end
      if (rstLink)
      begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge clkTxLine)
   begin
      s_r <= s_nxt;
   end

   assign loopCodeDetected = s_r.det;
   assign remoteLoopback   = (s_r.state == lttp_pkg::DET_LOOPED);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_off_clears;
      @(posedge clkTxLine) disable iff (rstLink)
      (loopCodeDetectMode == 2'h0) |=> !loopCodeDetected && !remoteLoopback;
   endproperty
   a_off_clears: assert property (p_off_clears)
      else $error("detector active while disabled");

   property p_up_qualify;
      @(posedge clkTxLine) disable iff (rstLink)
      (loopCodeDetectMode == 2'h1 && s_r.modePrev == 2'h1 && upOk &&
       s_r.cnt == qualCycles) |=> loopCodeDetected;
   endproperty
   a_up_qualify: assert property (p_up_qualify)
      else $error("loop-up code qualified but not flagged");

   property p_suppress;
      @(posedge clkTxLine) disable iff (rstLink)
      suppressAuto |=> !remoteLoopback;
   endproperty
   a_suppress: assert property (p_suppress)
      else $error("remote loop-back while sending loop-up");

   property p_restart;
      @(posedge clkTxLine) disable iff (rstLink)
      !codeOk |=> (s_r.cnt == '0) && !$rose(loopCodeDetected);
   endproperty
   a_restart: assert property (p_restart)
      else $error("qualification count survived a broken code");

   c_looped: cover property (@(posedge clkTxLine) $rose(remoteLoopback));
   c_unlooped: cover property (@(posedge clkTxLine) $fell(remoteLoopback));

endmodule

// ---- lttp_remote_model.sv ----
module lttp_remote_model
(
   input  wire logic       clkTxLine,
   input  wire logic [1:0] codeSel,
   output      logic       rxLineData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] phase = 3'h0;
   logic [2:0] last;
   // Up 00001 at 1, a 10 idle that holds neither code at 0, else down 001
   assign last = codeSel == 2'h1 ? 3'h4 : (codeSel == 2'h0 ? 3'h1 : 3'h2);
   always @(posedge clkTxLine)
   begin
      phase <= phase >= last ? 3'h0 : phase + 3'h1;
      rxLineData <= phase == last;
   end
endmodule

// ---- tb_line_test_pattern_control.sv ----
module tb_line_test_pattern_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys = 1'b0;
   logic       clkTxLine = 1'b0;
   logic       lineRun = 1'b1;
   logic       reset = 1'b1;
   logic       txData = 1'b0;
   logic       rateIsE1 = 1'b0;
   logic       regWrEn, hostModePin, sendAllOnesPin, autoAllOnesPin, tipPrev;
   logic       autoAllOnesBit, loopCodeIrqEnable, txOnBit, rxTermSelBit;
   logic       transmitOnPin, rxTerminationSelect, receiveSignalLoss;
   logic       txLineTip, txLineRing, txEnable, rxTermInternal, rxLineData;
   logic       loopCodeDetected, remoteLoopback, loopCodeIrq, txLineClockLost;
   logic [7:0] regAddr, regWrData, regRdData, marks;
   logic [2:0] testPatternSelect;
   logic [1:0] loopCodeDetectMode, codeSel;
   int         errorCnt = 0;
   int         testsRun = 0;
   int         irqCnt = 0;
   logic [7:0] expMarks [5] = '{8'h00, 8'h1E, 8'h06, 8'h0A, 8'h1E};

   lttp_top #(.QUAL_T1_CYC(24'h000014), .QUAL_E1_CYC(24'h000019)) i_lttp_top
   (
      .clk_sys, .reset, .clkTxLine, .regWrEn, .regAddr, .regWrData,
      .regRdData, .hostModePin, .sendAllOnesPin, .autoAllOnesPin,
      .autoAllOnesBit, .testPatternSelect, .loopCodeDetectMode,
      .loopCodeIrqEnable, .rateIsE1, .txOnBit, .rxTermSelBit,
      .transmitOnPin, .rxTerminationSelect, .receiveSignalLoss,
      .txPositiveData(txData), .txNegativeData(txData), .rxLineData,
      .txLineTip, .txLineRing, .txEnable, .rxTermInternal, .loopCodeDetected,
      .remoteLoopback, .loopCodeIrq, .txLineClockLost
   );
   lttp_remote_model i_lttp_remote_model (.clkTxLine, .codeSel, .rxLineData);

   initial forever #2 clk_sys = ~clk_sys;
   initial
   begin
      #7;
      // Line clock keeps running unless a test stops it on purpose
      forever #62.5 clkTxLine = lineRun ? ~clkTxLine : clkTxLine;
   end
   always @(posedge clk_sys)
      if (loopCodeIrq === 1'b1)
         irqCnt <= irqCnt + 1;

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      {regWrEn, regAddr, regWrData} = {1'b1, a, d};
      @(negedge clk_sys);
      regWrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      regAddr = a;
      repeat (2) @(negedge clk_sys);
      check("regRdData", regRdData, exp);
   endtask
   // Skips 5 line bits so a pattern change has crossed before counting
   task automatic countMarks(input int n);
      repeat (5) @(negedge clkTxLine);
      marks = 8'h00;
      repeat (n)
      begin
         @(negedge clkTxLine);
         marks = marks + 8'(txLineTip | txLineRing);
      end
   endtask
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      {regWrEn, regAddr, regWrData, sendAllOnesPin, autoAllOnesPin} = '0;
      {autoAllOnesBit, txOnBit, rxTermSelBit, transmitOnPin} = '0;
      {rxTerminationSelect, receiveSignalLoss, testPatternSelect} = '0;
      {loopCodeDetectMode, codeSel, tipPrev} = '0;
      {hostModePin, loopCodeIrqEnable} = 2'h3;
      repeat (8) @(posedge clkTxLine);
      @(negedge clk_sys) reset = 1'b0;
      rd(8'h12, 8'h00);
      {transmitOnPin, rxTerminationSelect} = 2'h3;
      repeat (6) @(negedge clk_sys);
      check("txEnable", 8'(txEnable), 8'h00);
      wr(8'h12, 8'h20);
      wr(8'h33, 8'hFF);
      rd(8'h33, 8'h00);
      rd(8'h12, 8'h20);
      check("txEnable", 8'(txEnable), 8'h01);
      check("rxTerm", 8'(rxTermInternal), 8'h00);
      rxTermSelBit = 1'b1;
      repeat (3) @(negedge clk_sys);
      check("rxTerm", 8'(rxTermInternal), 8'h01);
      {transmitOnPin, txOnBit, rxTermSelBit} = 3'h2;
      wr(8'h12, 8'h10);
      repeat (6) @(negedge clk_sys);
      check("txEnable", 8'(txEnable), 8'h01);
      check("rxTerm", 8'(rxTermInternal), 8'h01);
      $display("test handover done");
      for (int p = 0; p < 5; p++)
      begin
         @(negedge clk_sys) testPatternSelect = 3'(p);
         txData = (p != 0);
         countMarks(30);
         check("marks", marks, expMarks[p]);
      end
      @(negedge clk_sys);
      {hostModePin, sendAllOnesPin, testPatternSelect} = 5'h08;
      countMarks(30);
      check("marks", marks, 8'h1E);
      @(negedge clk_sys) {hostModePin, sendAllOnesPin} = 2'h2;
      {autoAllOnesBit, receiveSignalLoss} = 2'h3;
      countMarks(30);
      check("marks", marks, 8'h1E);
      @(negedge clk_sys) {receiveSignalLoss, txData} = 2'h0;
      countMarks(30);
      check("marks", marks, 8'h00);
      $display("test patterns done");
      @(negedge clk_sys) {loopCodeDetectMode, codeSel} = 4'h5;
      countMarks(10);
      check("detected", 8'(loopCodeDetected), 8'h00);
      countMarks(30);
      check("detected", 8'(loopCodeDetected), 8'h01);
      @(negedge clk_sys) codeSel = 2'h0;
      countMarks(10);
      check("detected", 8'(loopCodeDetected), 8'h00);
      @(negedge clk_sys) {loopCodeDetectMode, codeSel} = 4'hA;
      countMarks(40);
      check("detected", 8'(loopCodeDetected), 8'h01);
      check("irqs", 8'(irqCnt), 8'h03);
      @(negedge clk_sys);
      {testPatternSelect, loopCodeDetectMode, codeSel} = 7'h2D;
      countMarks(40);
      check("loop", 8'({remoteLoopback, loopCodeDetected}), 8'h00);
      @(negedge clk_sys) testPatternSelect = 3'h0;
      countMarks(40);
      check("loop", 8'({remoteLoopback, loopCodeDetected}), 8'h03);
      @(negedge clk_sys) {codeSel, rateIsE1} = 3'h5;
      countMarks(40);
      check("loop", 8'({remoteLoopback, loopCodeDetected}), 8'h00);
      $display("test loop codes done");
      @(negedge clk_sys) {testPatternSelect, codeSel} = 5'h04;
      lineRun = 1'b0;
      repeat (400) @(negedge clk_sys);
      check("clkLost", 8'(txLineClockLost), 8'h01);
      marks = 8'h00;
      repeat (1620)
      begin
         @(negedge clk_sys);
         marks = marks + 8'(txLineTip !== tipPrev);
         tipPrev = txLineTip;
      end
      check("fallback", 8'(marks >= 8'h09 && marks <= 8'h0B), 8'h01);
      $display("test clock loss done");
      endOfTest();
   end
   initial
   begin
      #200us;
      errorCnt++;
      endOfTest();
   end
endmodule
